// File: rtl/tcr_readout.sv
// Module: channel sequencer and 16-point input image for the thermocouple readout
`timescale 1ns/1ps
`default_nettype none
module tcr_readout #(
  parameter int CONV_CYCLES = tcr_pkg::CONV_CYC
) (
  input wire logic core_clk, // 100 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic host_scan, // Host scan strobe, from pin
  input wire logic fahrenheit_select, // Jumper, from pin
  input wire logic raw_count_select, // Jumper, from pin
  input wire tcr_pkg::tcr_sample_t [7:0] conv_in, // Front-end results per channel
  output logic [7:0] conv_start, // Starts a channel conversion
  output tcr_pkg::tcr_image_t image // 16-point input image
);
  import tcr_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Both stages reset low, the strobe's idle level, so reset brings no false scan
  logic [2:0] s1_q, s2_q, s1_d, s2_d;
  logic scan_prev_q, scan_prev_d;
  always_comb begin
    s1_d = {host_scan, fahrenheit_select, raw_count_select};
    s2_d = s1_q;
    scan_prev_d = s2_q[2];
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      scan_prev_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      scan_prev_q <= scan_prev_d;
    end
  end
  wire logic scan_rise = s2_q[2] & ~scan_prev_q;
  wire logic fahr_sel = s2_q[1];
  wire logic raw_sel = s2_q[0];

  // ----------------------------------------
  // Background conversion, one channel at a time
  // ----------------------------------------
  // Open sensor outranks every mode so a broken wire never reads as a plausible value
  function automatic logic [DATA_W-1:0] pick(input tcr_sample_t s, input logic f, input logic r);
    if (s.open_err) pick = FULL_SCALE;
    else if (r) pick = s.raw;
    else if (f) pick = s.temp_f;
    else pick = s.temp_c;
  endfunction : pick

  typedef enum logic [0:0] {CV_RUN, CV_WAIT} tcr_cv_t;
  tcr_cv_t cv_q, cv_d;
  // A 32-bit timer holds the full conversion count at the core clock rate
  logic [31:0] tmr_q, tmr_d;
  logic [2:0] cch_q, cch_d;
  // Results are kept per channel, so a scan never waits on a conversion
  logic [DATA_W-1:0] res_q [CH_COUNT];
  logic [DATA_W-1:0] res_d [CH_COUNT];
  logic [CH_COUNT-1:0] sgn_q, sgn_d;
  logic [7:0] start_d;

  always_comb begin
    cv_d = cv_q;
    tmr_d = tmr_q;
    cch_d = cch_q;
    res_d = res_q;
    sgn_d = sgn_q;
    start_d = 8'h00;
    case (cv_q)
      CV_RUN: begin
        start_d[cch_q] = 1'b1;
        tmr_d = 32'(CONV_CYCLES - 1);
        cv_d = CV_WAIT;
      end
      CV_WAIT: begin
        if (tmr_q != 32'h0) begin
          tmr_d = tmr_q - 32'h1;
        end else if (conv_in[cch_q].valid) begin
          res_d[cch_q] = pick(conv_in[cch_q], fahr_sel, raw_sel);
          sgn_d[cch_q] = conv_in[cch_q].sign & ~raw_sel & ~conv_in[cch_q].open_err;
          cch_d = cch_q + 3'h1;
          cv_d = CV_RUN;
        end
      end
      default: cv_d = CV_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cv_q <= CV_RUN;
      tmr_q <= 32'h0;
      cch_q <= IDX_FIRST;
      sgn_q <= 8'h00;
      conv_start <= 8'h00;
      for (int i = 0; i < CH_COUNT; i++) begin
        res_q[i] <= FULL_SCALE;
      end
    end else begin
      cv_q <= cv_d;
      tmr_q <= tmr_d;
      cch_q <= cch_d;
      sgn_q <= sgn_d;
      conv_start <= start_d;
      res_q <= res_d;
    end
  end

  // ----------------------------------------
  // Host image: one channel per scan
  // ----------------------------------------
  // The whole image is loaded in one edge so index, sign and data never mix
  logic [2:0] pch_q, pch_d;
  tcr_image_t img_d;
  always_comb begin
    pch_d = pch_q;
    img_d = image;
    if (scan_rise) begin
      img_d.idx = pch_q;
      img_d.data = res_q[pch_q];
      img_d.sign = sgn_q[pch_q];
      pch_d = (pch_q == IDX_LAST) ? IDX_FIRST : pch_q + 3'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pch_q <= IDX_FIRST;
      image <= '0;
    end else begin
      pch_q <= pch_d;
      image <= img_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  image_steady_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !$past(scan_rise) |-> $stable(image)) else $error("image changed without a scan");
  index_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
    scan_rise |=> image.idx == $past(pch_q)) else $error("wrong channel index shown");
  index_wrap_a: assert property (@(posedge core_clk) disable iff (!rstn)
    scan_rise && pch_q == IDX_LAST |=> pch_q == IDX_FIRST) else $error("no wrap after eighth");
  image_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    scan_rise |=> image.data == $past(res_q[pch_q]) && image.sign == $past(sgn_q[pch_q]))
    else $error("image not loaded from one channel");
  scan_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !scan_rise |=> pch_q == $past(pch_q))
    else $error("channel pointer moved without a scan");
  scan_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    scan_rise |=> !scan_rise)
    else $error("one strobe counted twice");
  sync_edge_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(s2_q[2]) |-> scan_rise)
    else $error("synchronised strobe edge not seen");

  // ----------------------------------------
  // Conversion checks
  // ----------------------------------------
  // Cycles since the last start pulse; kept only for the checks below
  logic [31:0] since_q, since_d;
  wire logic store_now = cv_q == CV_WAIT && tmr_q == 32'h0 && conv_in[cch_q].valid;
  always_comb begin
    since_d = (|conv_start) ? 32'h1 : since_q + 32'h1;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      since_q <= 32'h0;
    end else begin
      since_q <= since_d;
    end
  end

  conv_min_a: assert property (@(posedge core_clk) disable iff (!rstn)
    |conv_start |-> ##1 cv_q == CV_WAIT [*8]) else $error("conversion ended early");
  conv_long_a: assert property (@(posedge core_clk) disable iff (!rstn)
    store_now |-> since_q + 32'h1 >= 32'(CONV_CYCLES))
    else $error("result stored before the conversion time");
  timer_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cv_q == CV_RUN |=> tmr_q == 32'(CONV_CYCLES - 1))
    else $error("conversion timer not loaded");
  wait_stay_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cv_q == CV_WAIT && !store_now |=> cv_q == CV_WAIT)
    else $error("conversion left before its result");
  run_once_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cv_q == CV_RUN |=> cv_q == CV_WAIT && $onehot(conv_start))
    else $error("start state did not launch a conversion");
  start_gap_a: assert property (@(posedge core_clk) disable iff (!rstn)
    |conv_start |=> !(|conv_start))
    else $error("start pulse longer than one cycle");
  start_chan_a: assert property (@(posedge core_clk) disable iff (!rstn)
    |conv_start |-> conv_start[cch_q] && cv_q == CV_WAIT)
    else $error("start pulse for the wrong channel");
  chan_next_a: assert property (@(posedge core_clk) disable iff (!rstn)
    store_now |=> cv_q == CV_RUN && cch_q == $past(cch_q) + 3'h1)
    else $error("conversion did not move to the next channel");
  open_full_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cv_q == CV_WAIT && tmr_q == 32'h0 && conv_in[cch_q].valid && conv_in[cch_q].open_err
    |=> res_q[$past(cch_q)] == FULL_SCALE) else $error("open sensor not full scale");
  raw_pick_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cv_q == CV_WAIT && tmr_q == 32'h0 && conv_in[cch_q].valid && !conv_in[cch_q].open_err && raw_sel
    |=> res_q[$past(cch_q)] == $past(conv_in[cch_q].raw)) else $error("raw count not used");
  fahr_pick_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cv_q == CV_WAIT && tmr_q == 32'h0 && conv_in[cch_q].valid && !conv_in[cch_q].open_err
    && !raw_sel && fahr_sel |=> res_q[$past(cch_q)] == $past(conv_in[cch_q].temp_f))
    else $error("fahrenheit not used");
  cels_pick_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cv_q == CV_WAIT && tmr_q == 32'h0 && conv_in[cch_q].valid && !conv_in[cch_q].open_err
    && !raw_sel && !fahr_sel |=> res_q[$past(cch_q)] == $past(conv_in[cch_q].temp_c))
    else $error("celsius not used");
  sign_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    store_now && (raw_sel || conv_in[cch_q].open_err) |=> !sgn_q[$past(cch_q)])
    else $error("sign kept in raw mode or on open sensor");
  sign_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
    store_now && !raw_sel && !conv_in[cch_q].open_err
    |=> sgn_q[$past(cch_q)] == $past(conv_in[cch_q].sign))
    else $error("temperature sign not stored");
  one_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $onehot0(conv_start)) else $error("several channels started");
endmodule : tcr_readout
`default_nettype wire

// File: rtl/tcr_pkg.sv
// Package: constants and carrier types for the eight-channel thermocouple readout
// What this block does
// - Eight differential channels, each result delivered as a 12-bit value.
// - Exactly one channel result is presented on each host scan.
// - Each channel conversion lasts at least fifteen milliseconds.
// - Open sensor or input error reports full scale for that channel.
// - Temperature mode delivers direct temperature readings, no host scaling needed.
// - Celsius readings are the factory default.
// - Fahrenheit select fitted gives Fahrenheit; absent gives Celsius.
// - Raw-count select bypasses temperature conversion, linear 0 to 4095 count.
// - Raw mode type E: zero at range bottom, full scale at top.
// - Millivolt variants map input span linearly onto zero to full scale.
// - Device occupies sixteen input points; host slot must be sixteen wide.
// - Upper byte carries 3-bit channel index, 000 first through 111 eighth.
// - After the eighth channel the next scan presents the first again.
// - Most significant input bit is the temperature sign flag.
`default_nettype none
package tcr_pkg;
  localparam int CH_COUNT = 8;
  localparam int DATA_W = 12;
  localparam int IDX_W = 3;
  localparam int IMG_W = 16;
  localparam logic [11:0] FULL_SCALE = 12'hFFF;
  localparam logic [2:0] IDX_LAST = 3'h7;
  localparam logic [2:0] IDX_FIRST = 3'h0;
  // Conversion time and clock rate
  localparam int CONV_MS = 15;
  localparam int CLK_HZ = 100_000_000;
  localparam int CONV_CYC = CONV_MS * (CLK_HZ / 1000);
  // Image layout: data 11:0, index 14:12, sign 15
  localparam int IMG_DATA_LSB = 0;
  localparam int IMG_IDX_LSB = 12;
  localparam int IMG_SIGN_BIT = 15;

  typedef struct packed {
    logic sign;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } tcr_image_t;

  typedef struct packed {
    logic valid;
    logic sign;
    logic open_err;
    logic [DATA_W-1:0] temp_c;
    logic [DATA_W-1:0] temp_f;
    logic [DATA_W-1:0] raw;
  } tcr_sample_t;
endpackage : tcr_pkg
`default_nettype wire

// File: verif/tcr_host_model.sv
// Model of the controller that scans the readout once per request
`timescale 1ns/1ps
`default_nettype none
module tcr_host_model (
  input wire logic core_clk, // Bench clock
  input wire logic scan_go, // Request for one scan
  output logic host_scan, // Scan strobe to the readout
  input wire tcr_pkg::tcr_image_t image, // Image from the readout
  output tcr_pkg::tcr_image_t seen // Image taken by this scan
);
  import tcr_pkg::*;
  // Strobe is held three cycles so the two-stage synchroniser cannot miss it
  initial begin
    host_scan = 1'b0;
    seen = '0;
    forever begin
      @(posedge core_clk iff scan_go);
      #1 host_scan = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 host_scan = 1'b0;
      repeat (5) @(posedge core_clk);
      seen = image;
    end
  end
endmodule : tcr_host_model
`default_nettype wire

// File: verif/thermocouple_channel_readout_bench.sv
// Self-checking bench for the thermocouple readout
`timescale 1ns/1ps
`default_nettype none
module thermocouple_channel_readout_bench;
  import tcr_pkg::*;
  localparam int CONV = 12;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic scan_go = 1'b0;
  logic fahrenheit_select = 1'b0;
  logic raw_count_select = 1'b0;
  logic host_scan;
  tcr_sample_t [7:0] conv_in;
  logic [7:0] conv_start;
  tcr_image_t image;
  tcr_image_t seen;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [2:0] nxt = 3'h0;
  always #5 core_clk = ~core_clk;
  tcr_readout #(.CONV_CYCLES(CONV)) dut (.core_clk(core_clk), .rstn(rstn), .host_scan(host_scan),
    .fahrenheit_select(fahrenheit_select), .raw_count_select(raw_count_select), .conv_in(conv_in),
    .conv_start(conv_start), .image(image));
  tcr_host_model host (.core_clk(core_clk), .scan_go(scan_go), .host_scan(host_scan), .image(image), .seen(seen));
  // ----------------------------------------
  // Front end: channel 5 open, raw span ends on channels 0 and 7
  // ----------------------------------------
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      conv_in[n].valid = 1'b1;
      conv_in[n].sign = n[0];
      conv_in[n].open_err = (n == 5);
      conv_in[n].temp_c = 12'h100 + 12'(n);
      conv_in[n].temp_f = 12'h200 + 12'(n);
      conv_in[n].raw = (n == 0) ? 12'h000 : (n == 7) ? FULL_SCALE : 12'h300 + 12'(n);
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("Counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  function automatic tcr_image_t expect_img(input logic [2:0] i);
    tcr_image_t e;
    e.idx = i;
    e.sign = i[0] & ~raw_count_select & (i != 3'h5);
    if (i == 3'h5) e.data = FULL_SCALE;
    else if (raw_count_select) e.data = conv_in[i].raw;
    else if (fahrenheit_select) e.data = conv_in[i].temp_f;
    else e.data = conv_in[i].temp_c;
    return e;
  endfunction : expect_img
  task automatic scan_once();
    check(image, seen);
    @(posedge core_clk) #1 scan_go = 1'b1;
    @(posedge core_clk) #1 scan_go = 1'b0;
    repeat (12) @(posedge core_clk);
    check(seen, expect_img(nxt));
    nxt = nxt + 3'h1;
  endtask : scan_once
  // Jumpers are given time for every channel to reconvert in the new mode
  task automatic test_mode(input logic f, input logic r);
    @(posedge core_clk) #1 fahrenheit_select = f;
    raw_count_select = r;
    repeat (300) @(posedge core_clk);
    repeat (9) scan_once();
    $display("Test mode f=%0b r=%0b done", f, r);
  endtask : test_mode
  task automatic test_conv_time();
    int gap;
    gap = 0;
    for (int k = 0; k < 100 && conv_start == 8'h00; k++) @(posedge core_clk) #1;
    check(16'($onehot(conv_start)), 16'h0001);
    check(16'(conv_start), 16'h0001);
    @(posedge core_clk) #1;
    while (conv_start == 8'h00 && gap < 100) begin
      gap++;
      @(posedge core_clk) #1;
    end
    check(16'(gap >= CONV), 16'h0001);
    check(16'(conv_start), 16'h0002);
    $display("Test conversion time done");
  endtask : test_conv_time
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rstn = 1'b1;
    check(image, 16'h0000);
    test_conv_time();
    test_mode(1'b0, 1'b0);
    test_mode(1'b1, 1'b0);
    test_mode(1'b1, 1'b1);
    conclude();
  end
endmodule : thermocouple_channel_readout_bench
`default_nettype wire
